// ==== verilog/fpc_consts.svh ====
// constants for the framer primary control and interrupt request block
// assumes an 8-bit processor port with a 9-bit address and a 25 MHz clock
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define FPC_ADDR_CR0    9'h001
`define FPC_ADDR_IRR    9'h003
`define FPC_ADDR_ISR_LO 9'h004
`define FPC_ADDR_ISR_HI 9'h00B
`define FPC_ADDR_IER_LO 9'h00C
`define FPC_ADDR_IER_HI 9'h013

// ----------------------------------------------------------------------
// primary control fields and defaults
// ----------------------------------------------------------------------
`define FPC_CR0_RESET_BIT 7
`define FPC_CR0_INCF_BIT  5
`define FPC_CR0_MODE_HI   4
`define FPC_CR0_MODE_LO   1
`define FPC_CR0_RATE_BIT  0
`define FPC_CR0_FLD_W     7
`define FPC_CR0_DEF       7'h00
`define FPC_CR0_FLD_MASK  7'h3F
`define FPC_IER_DEF       8'h00
`define FPC_DATA_ZERO     8'h00
`define FPC_NGRP          8
`define FPC_PIO_W         8
`define FPC_PIO_DEF       8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FPC_RST_TIME_NS   15000
`define FPC_CLK_PERIOD_NS 40
`define FPC_RST_CYCLES    (`FPC_RST_TIME_NS / `FPC_CLK_PERIOD_NS)
`define FPC_CNT_W         9

`endif

// ==== verilog/fpc_pkg.sv ====
// types shared by the framer primary control block
// assumes the constants header is compiled alongside
package fpc_pkg;

  // ----------------------------------------------------------------------
  // receive framer mode in t1 operation
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    FPC_T1_FT_ONLY,
    FPC_T1_ESF_NO_CRC,
    FPC_T1_SF,
    FPC_T1_SF_JAPANESE_YELLOW_ALARM,
    FPC_T1_SF_T1DM,
    FPC_T1_LC_FLOSS,
    FPC_T1_LC,
    FPC_T1_ESF_MIMIC,
    FPC_T1_ESF_FORCE,
    FPC_T1_UNDEF
  } fpc_t1_mode_e;

endpackage

// ==== verilog/fpc_reset_seq.sv ====
// self-timed framer reset sequencer
// assumes start is a same-clock pulse or level; rst is power-up reset
`timescale 1ns/1ps
`include "fpc_consts.svh"

module fpc_reset_seq (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);
  import fpc_pkg::*;

  localparam logic [`FPC_CNT_W-1:0] LAST =
    `FPC_CNT_W'(`FPC_RST_CYCLES - 1);

  logic                  busy_r;
  logic                  busy_nxt;
  logic [`FPC_CNT_W-1:0] cnt_r;
  logic [`FPC_CNT_W-1:0] cnt_nxt;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // a new trigger restarts the full interval so the reset never ends early
  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt  = cnt_r;
    if (start) begin
      busy_nxt = 1'b1;
      cnt_nxt  = '0;
    end else if (busy_r) begin
      if (cnt_r == LAST) begin
        busy_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // power-up counts as a trigger
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_r <= 1'b1;
      cnt_r  <= '0;
    end else begin
      busy_r <= busy_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign busy = busy_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // own length counter, so the interval is not judged by cnt_r itself
  logic [`FPC_CNT_W-1:0] run_len_r;
  logic [`FPC_CNT_W-1:0] run_len_nxt;

  always_comb begin
    run_len_nxt = run_len_r;
    if (start) begin
      run_len_nxt = '0;
    end else if (busy_r) begin
      run_len_nxt = run_len_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      run_len_r <= '0;
    end else begin
      run_len_r <= run_len_nxt;
    end
  end

  reset_length_a: assert property (@(posedge clock) disable iff (rst)
    $fell(busy_r) |-> $past(run_len_r) == LAST)
    else $error("framer reset interval has wrong length");

  reset_bound_a: assert property (@(posedge clock) disable iff (rst)
    busy_r |-> run_len_r <= LAST)
    else $error("framer reset ran past its interval");

endmodule

// ==== verilog/fpc_framer_ctrl.sv ====
// framer primary control register and interrupt request summary
// assumes a same-clock 8-bit processor port; rst_pin_n is asynchronous
//
// Operation
// - writing reset bit starts bounded internal reset
// - reset bit reads one while reset runs
// - power-up, global and pin resets also run
// - after reset outputs released, controls defaulted
// - t1 crc6 uses one unless fbit included
// - include option ignored in e1 mode
// - mode field sets frame search criteria
// - e1 mode bits add bitslip, crc, cas
// - t1 mode codes decode to framing types
// - rate select chooses e1 or t1
// - enabled status event latches request bit
// - status read clears request bit
// - request bits ored to master and pin
// - request bit n maps to status n
// - bit one from second link or codeword
// - bit zero from pattern or frame errors
// - status read clears latched status bits
// - master enable gates master bit and pin
`timescale 1ns/1ps
`include "fpc_consts.svh"

module fpc_framer_ctrl (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    rst_pin_n,
  input  wire logic                    global_soft_reset,
  input  wire logic                    master_irq_enable,
  input  wire logic [8:0]              addr,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  input  wire logic [7:0]              wdata,
  input  wire logic [63:0]             src_event,
  input  wire logic                    rx_fbit,
  input  wire logic                    sysbus_enable,
  input  wire logic [`FPC_PIO_W-1:0]   pio_dir_request,
  output logic      [7:0]              rdata,
  output logic                         crc_fbit,
  output logic                         line_rate_t1,
  output logic                         e1_bit_slip_detect_en,
  output logic                         e1_crc_en,
  output logic                         e1_cas_en,
  output fpc_pkg::fpc_t1_mode_e        t1_mode,
  output logic                         master_irq_bit,
  output logic                         irq_out_n,
  output logic                         sysbus_drive_en,
  output logic      [`FPC_PIO_W-1:0]   pio_dir_out
);
  import fpc_pkg::*;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic in_span(input logic [8:0] a,
                                   input logic [8:0] lo,
                                   input logic [8:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  // lower address holds the higher group number
  function automatic logic [2:0] grp_of(input logic [8:0] a,
                                        input logic [8:0] hi);
    logic [8:0] d;
    d = hi - a;
    grp_of = d[2:0];
  endfunction

  function automatic fpc_t1_mode_e t1_decode(input logic [3:0] m);
    case (m)
      4'h0: t1_decode = FPC_T1_FT_ONLY;
      4'h1: t1_decode = FPC_T1_ESF_NO_CRC;
      4'h4: t1_decode = FPC_T1_SF;
      4'h5: t1_decode = FPC_T1_SF_JAPANESE_YELLOW_ALARM;
      4'h6: t1_decode = FPC_T1_SF_T1DM;
      4'h8: t1_decode = FPC_T1_LC_FLOSS;
      4'h9: t1_decode = FPC_T1_LC;
      4'hC: t1_decode = FPC_T1_ESF_MIMIC;
      4'hD: t1_decode = FPC_T1_ESF_FORCE;
      default: t1_decode = FPC_T1_UNDEF;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // reset pin synchroniser and reset sequencer
  // ----------------------------------------------------------------------
  logic pin_s1_r;
  logic pin_s2_r;
  logic busy;
  logic start;

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= rst_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic wr_cr0;
  logic wr_isr;
  logic wr_ier;
  logic rd_isr;
  logic [2:0] isr_grp;
  logic [2:0] ier_grp;

  always_comb begin
    wr_cr0  = 1'b0;
    wr_ier  = 1'b0;
    wr_isr  = 1'b0;
    rd_isr  = 1'b0;
    isr_grp = grp_of(addr, `FPC_ADDR_ISR_HI);
    ier_grp = grp_of(addr, `FPC_ADDR_IER_HI);
    if (addr == `FPC_ADDR_CR0) begin
      wr_cr0 = wr_en;
    end else if (in_span(addr, `FPC_ADDR_ISR_LO, `FPC_ADDR_ISR_HI)) begin
      rd_isr = rd_en;
      wr_isr = wr_en;
    end else if (in_span(addr, `FPC_ADDR_IER_LO, `FPC_ADDR_IER_HI)) begin
      wr_ier = wr_en;
    end
  end

  // held low pin keeps restarting, so reset ends 15 us after the release leaves the two-flop synchroniser
  assign start = (wr_cr0 && wdata[`FPC_CR0_RESET_BIT])
               || global_soft_reset || !pin_s2_r;

  fpc_reset_seq u_seq (
    .clock (clock),
    .rst   (rst),
    .start (start),
    .busy  (busy)
  );

  // ----------------------------------------------------------------------
  // primary control fields
  // ----------------------------------------------------------------------
  logic [`FPC_CR0_FLD_W-1:0] cr0_r;
  logic [`FPC_CR0_FLD_W-1:0] cr0_nxt;

  // writes during reset are dropped; a zero in the reset bit does nothing
  always_comb begin
    cr0_nxt = cr0_r;
    if (busy || start) begin
      cr0_nxt = `FPC_CR0_DEF;
    end else if (wr_cr0) begin
      cr0_nxt = wdata[`FPC_CR0_FLD_W-1:0] & `FPC_CR0_FLD_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cr0_r <= `FPC_CR0_DEF;
    end else begin
      cr0_r <= cr0_nxt;
    end
  end

  logic       incf;
  logic [3:0] mode;
  logic       t1;
  assign incf = cr0_r[`FPC_CR0_INCF_BIT];
  assign mode = cr0_r[`FPC_CR0_MODE_HI:`FPC_CR0_MODE_LO];
  assign t1   = cr0_r[`FPC_CR0_RATE_BIT];

  // ----------------------------------------------------------------------
  // framer configuration outputs
  // ----------------------------------------------------------------------
  logic                  fbit_nxt;
  logic                  bit_slip_detect_nxt;
  logic                  crc_nxt;
  logic                  cas_nxt;
  fpc_t1_mode_e          t1m_nxt;
  logic                  sb_nxt;
  logic [`FPC_PIO_W-1:0] pio_nxt;

  always_comb begin
    fbit_nxt = rx_fbit;
    if (t1 && !incf) begin
      fbit_nxt = 1'b1;
    end
    bit_slip_detect_nxt = !t1 && mode[1];
    crc_nxt   = !t1 && mode[2];
    cas_nxt   = !t1 && mode[3];
    t1m_nxt   = t1 ? t1_decode(mode) : FPC_T1_UNDEF;
    sb_nxt    = sysbus_enable && !busy && !start;
    pio_nxt   = (busy || start) ? `FPC_PIO_DEF : pio_dir_request;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      crc_fbit        <= 1'b1;
      line_rate_t1    <= 1'b0;
      e1_bit_slip_detect_en     <= 1'b0;
      e1_crc_en       <= 1'b0;
      e1_cas_en       <= 1'b0;
      t1_mode         <= FPC_T1_UNDEF;
      sysbus_drive_en <= 1'b0;
      pio_dir_out     <= `FPC_PIO_DEF;
    end else begin
      crc_fbit        <= fbit_nxt;
      line_rate_t1    <= t1;
      e1_bit_slip_detect_en     <= bit_slip_detect_nxt;
      e1_crc_en       <= crc_nxt;
      e1_cas_en       <= cas_nxt;
      t1_mode         <= t1m_nxt;
      sysbus_drive_en <= sb_nxt;
      pio_dir_out     <= pio_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // status, enable and request per group
  // ----------------------------------------------------------------------
  // group n: 7 rx alarm, 6 second alarm, 5 error, 4 count, 3 timer,
  // 2 link one, 1 link two or codeword, 0 pattern or tx frame error
  logic [`FPC_NGRP-1:0][7:0] isr_r;
  logic [`FPC_NGRP-1:0][7:0] isr_nxt;
  logic [`FPC_NGRP-1:0][7:0] ier_r;
  logic [`FPC_NGRP-1:0][7:0] ier_nxt;
  logic [`FPC_NGRP-1:0]      irr_r;
  logic [`FPC_NGRP-1:0]      irr_nxt;
  logic [`FPC_NGRP-1:0]      hit;

  genvar n;
  generate
    for (n = 0; n < `FPC_NGRP; n = n + 1) begin : g_grp
      logic [7:0] ev;
      assign ev     = src_event[n*8 +: 8];
      assign hit[n] = |(ev & ier_r[n]);

      // a new event in the clearing cycle survives the read
      always_comb begin
        isr_nxt[n] = isr_r[n];
        ier_nxt[n] = ier_r[n];
        irr_nxt[n] = irr_r[n];
        if (rd_isr && isr_grp == 3'(n)) begin
          isr_nxt[n] = '0;
          irr_nxt[n] = 1'b0;
        end
        isr_nxt[n] = isr_nxt[n] | ev;
        if (hit[n]) begin
          irr_nxt[n] = 1'b1;
        end
        if (busy || start) begin
          ier_nxt[n] = `FPC_IER_DEF;
        end else if (wr_ier && ier_grp == 3'(n)) begin
          ier_nxt[n] = wdata;
        end
      end

      irr_set_a: assert property (@(posedge clock) disable iff (rst)
        hit[n] |=> irr_r[n])
        else $error("enabled event did not latch request");

      irr_clear_a: assert property (@(posedge clock) disable iff (rst)
        rd_isr && isr_grp == 3'(n) && !hit[n] |=> !irr_r[n])
        else $error("status read did not clear request");
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      isr_r <= '0;
      ier_r <= '0;
      irr_r <= '0;
    end else begin
      isr_r <= isr_nxt;
      ier_r <= ier_nxt;
      irr_r <= irr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // master interrupt
  // ----------------------------------------------------------------------
  logic mir_nxt;
  assign mir_nxt = master_irq_enable && (|irr_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      master_irq_bit <= 1'b0;
      irq_out_n      <= 1'b1;
    end else begin
      master_irq_bit <= mir_nxt;
      irq_out_n      <= !mir_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  logic [7:0] rdata_nxt;

  // status reads return the bits latched before this cycle's events
  always_comb begin
    rdata_nxt = rdata;
    if (rd_en) begin
      if (addr == `FPC_ADDR_CR0) begin
        rdata_nxt = {busy, cr0_r};
      end else if (addr == `FPC_ADDR_IRR) begin
        rdata_nxt = irr_r;
      end else if (in_span(addr, `FPC_ADDR_ISR_LO, `FPC_ADDR_ISR_HI)) begin
        rdata_nxt = isr_r[isr_grp];
      end else if (in_span(addr, `FPC_ADDR_IER_LO, `FPC_ADDR_IER_HI)) begin
        rdata_nxt = ier_r[ier_grp];
      end else begin
        rdata_nxt = `FPC_DATA_ZERO;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= `FPC_DATA_ZERO;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence cr0_read_s;
    rd_en && addr == `FPC_ADDR_CR0;
  endsequence

  reset_readback_a: assert property (@(posedge clock) disable iff (rst)
    cr0_read_s ##0 busy |=> rdata[`FPC_CR0_RESET_BIT])
    else $error("reset bit not seen during reset");

  crc_subst_a: assert property (@(posedge clock) disable iff (rst)
    t1 && !incf |=> crc_fbit)
    else $error("t1 crc f-bit not replaced by one");

  // sampled rst skips the release edge, where the flop still takes reset
  e1_ignore_a: assert property (@(posedge clock) disable iff (rst)
    !rst && !t1 |=> crc_fbit == $past(rx_fbit))
    else $error("e1 crc f-bit altered by option");

  outputs_off_a: assert property (@(posedge clock) disable iff (rst)
    busy |=> !sysbus_drive_en && pio_dir_out == `FPC_PIO_DEF)
    else $error("outputs driven during framer reset");

  mie_gate_a: assert property (@(posedge clock) disable iff (rst)
    !master_irq_enable |=> !master_irq_bit && irq_out_n)
    else $error("interrupt passed with master enable low");

  irq_or_a: assert property (@(posedge clock) disable iff (rst)
    master_irq_enable && (|irr_r) |=> master_irq_bit && !irq_out_n)
    else $error("pending request did not raise interrupt");

  e1_mode_a: assert property (@(posedge clock) disable iff (rst)
    !t1 |=> e1_crc_en == $past(mode[2]) && t1_mode == FPC_T1_UNDEF)
    else $error("e1 mode bits decoded wrongly");

  wr_zero_a: assert property (@(posedge clock) disable iff (rst)
    busy && !start |=> cr0_r == `FPC_CR0_DEF)
    else $error("control written during framer reset");

endmodule

// ==== sim/fpc_framer_ctrl_tb_top.sv ====
// self-checking bench for the framer primary control block
// assumes design files and constants header are compiled first
`timescale 1ns/1ps
`include "fpc_consts.svh"

module fpc_framer_ctrl_tb_top;
  import fpc_pkg::*;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic                  clock             = 1'b0;
  logic                  rst               = 1'b1;
  logic                  rst_pin_n         = 1'b1;
  logic                  global_soft_reset = 1'b0;
  logic                  master_irq_enable = 1'b0;
  logic [8:0]            addr              = 9'h000;
  logic                  wr_en             = 1'b0;
  logic                  rd_en             = 1'b0;
  logic [7:0]            wdata             = 8'h00;
  logic [63:0]           src_event         = 64'h0;
  logic                  rx_fbit           = 1'b0;
  logic                  sysbus_enable     = 1'b1;
  logic [`FPC_PIO_W-1:0] pio_dir_request   = 8'hFF;
  logic [7:0]            rdata;
  logic                  crc_fbit;
  logic                  line_rate_t1;
  logic                  e1_bit_slip_detect_en;
  logic                  e1_crc_en;
  logic                  e1_cas_en;
  fpc_t1_mode_e          t1_mode;
  logic                  master_irq_bit;
  logic                  irq_out_n;
  logic                  sysbus_drive_en;
  logic [`FPC_PIO_W-1:0] pio_dir_out;
  int                    miscompares       = 0;
  int                    check_count       = 0;

  always #20 clock = ~clock;

  fpc_framer_ctrl u_fpc_framer_ctrl (
    .clock             (clock),
    .rst               (rst),
    .rst_pin_n         (rst_pin_n),
    .global_soft_reset (global_soft_reset),
    .master_irq_enable (master_irq_enable),
    .addr              (addr),
    .wr_en             (wr_en),
    .rd_en             (rd_en),
    .wdata             (wdata),
    .src_event         (src_event),
    .rx_fbit           (rx_fbit),
    .sysbus_enable     (sysbus_enable),
    .pio_dir_request   (pio_dir_request),
    .rdata             (rdata),
    .crc_fbit          (crc_fbit),
    .line_rate_t1      (line_rate_t1),
    .e1_bit_slip_detect_en       (e1_bit_slip_detect_en),
    .e1_crc_en         (e1_crc_en),
    .e1_cas_en         (e1_cas_en),
    .t1_mode           (t1_mode),
    .master_irq_bit    (master_irq_bit),
    .irq_out_n         (irq_out_n),
    .sysbus_drive_en   (sysbus_drive_en),
    .pio_dir_out       (pio_dir_out)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // registered decodes may trail the register by a cycle or two
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // polls the busy flag; a hang ends the run
  task automatic wait_done;
    logic [7:0] d;
    time        t0;
    int         n;
    t0 = $time;
    d  = 8'h80;
    n  = 0;
    while (d[7] && n < 400) begin
      rd(`FPC_ADDR_CR0, d);
      n++;
    end
    if (d[7]) begin
      miscompares++;
      $display("[ERR] %0t reset never finished", $time);
      results();
    end
    chk({7'h0, ($time - t0) <= 378 * 40}, 8'h01);
  endtask

  task automatic pulse(input logic [63:0] v);
    @(posedge clock);
    src_event <= v;
    @(posedge clock);
    src_event <= 64'h0;
    settle();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_power;
    rdc(`FPC_ADDR_CR0, 8'h80);
    chk({7'h0, sysbus_drive_en}, 8'h00);
    chk(pio_dir_out, 8'h00);
    chk({7'h0, irq_out_n}, 8'h01);
    wr(`FPC_ADDR_CR0, 8'h3F);
    wait_done();
    rdc(`FPC_ADDR_CR0, 8'h00);
    chk({7'h0, sysbus_drive_en}, 8'h01);
    chk(pio_dir_out, 8'hFF);
    rdc(9'h1FF, 8'h00);
  endtask

  task automatic t_modes;
    logic [3:0]   cd[10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6,
                             4'h8, 4'h9, 4'hC, 4'hD, 4'h2};
    fpc_t1_mode_e md[10] = '{FPC_T1_FT_ONLY, FPC_T1_ESF_NO_CRC,
                             FPC_T1_SF, FPC_T1_SF_JAPANESE_YELLOW_ALARM, FPC_T1_SF_T1DM,
                             FPC_T1_LC_FLOSS, FPC_T1_LC, FPC_T1_ESF_MIMIC,
                             FPC_T1_ESF_FORCE, FPC_T1_UNDEF};
    for (int i = 0; i < 10; i++) begin
      wr(`FPC_ADDR_CR0, {3'h0, cd[i], 1'b1});
      settle();
      chk({4'h0, t1_mode}, {4'h0, md[i]});
      chk({7'h0, line_rate_t1}, 8'h01);
      rdc(`FPC_ADDR_CR0, {3'h0, cd[i], 1'b1});
    end
    for (int m = 0; m < 16; m++) begin
      wr(`FPC_ADDR_CR0, {3'h0, 4'(m), 1'b0});
      settle();
      chk({5'h0, e1_cas_en, e1_crc_en, e1_bit_slip_detect_en},
          {5'h0, 3'(m >> 1)});
      chk({4'h0, t1_mode}, {4'h0, FPC_T1_UNDEF});
      chk({7'h0, line_rate_t1}, 8'h00);
    end
  endtask

  task automatic t_crc;
    rx_fbit <= 1'b0;
    wr(`FPC_ADDR_CR0, 8'h01);
    settle();
    chk({7'h0, crc_fbit}, 8'h01);
    wr(`FPC_ADDR_CR0, 8'h21);
    settle();
    chk({7'h0, crc_fbit}, 8'h00);
    rx_fbit <= 1'b1;
    settle();
    chk({7'h0, crc_fbit}, 8'h01);
    rx_fbit <= 1'b0;
    wr(`FPC_ADDR_CR0, 8'h00);
    settle();
    chk({7'h0, crc_fbit}, 8'h00);
    wr(`FPC_ADDR_CR0, 8'h20);
    settle();
    chk({7'h0, crc_fbit}, 8'h00);
  endtask

  task automatic t_soft;
    wr(`FPC_ADDR_CR0, 8'h21);
    wr(`FPC_ADDR_CR0, 8'hA1);
    rdc(`FPC_ADDR_CR0, 8'h80);
    wr(`FPC_ADDR_CR0, 8'h01);
    wait_done();
    rdc(`FPC_ADDR_CR0, 8'h00);
    chk({7'h0, line_rate_t1}, 8'h00);
    @(posedge clock);
    global_soft_reset <= 1'b1;
    @(posedge clock);
    global_soft_reset <= 1'b0;
    rdc(`FPC_ADDR_CR0, 8'h80);
    wait_done();
    @(posedge clock);
    rst_pin_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_pin_n <= 1'b1;
    settle();
    rdc(`FPC_ADDR_CR0, 8'h80);
    wait_done();
  endtask

  task automatic t_irq;
    logic [8:0] irq_status_reg;
    master_irq_enable <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      irq_status_reg = 9'(`FPC_ADDR_ISR_LO + 7 - n);
      wr(9'(`FPC_ADDR_IER_LO + 7 - n), 8'h01);
      pulse(64'h3 << (8 * n));
      rdc(`FPC_ADDR_IRR, 8'h01 << n);
      chk({6'h0, master_irq_bit, irq_out_n}, 8'h02);
      rdc(irq_status_reg, 8'h03);
      rdc(irq_status_reg, 8'h00);
      rdc(`FPC_ADDR_IRR, 8'h00);
      settle();
      chk({6'h0, master_irq_bit, irq_out_n}, 8'h01);
      pulse(64'h2 << (8 * n));
      rdc(`FPC_ADDR_IRR, 8'h00);
      rdc(irq_status_reg, 8'h02);
    end
    master_irq_enable <= 1'b0;
    pulse(64'h0100_0000_0000_0001);
    rdc(`FPC_ADDR_IRR, 8'h81);
    chk({6'h0, master_irq_bit, irq_out_n}, 8'h01);
    master_irq_enable <= 1'b1;
    settle();
    chk({6'h0, master_irq_bit, irq_out_n}, 8'h02);
    rdc(`FPC_ADDR_ISR_LO, 8'h01);
    settle();
    chk({6'h0, master_irq_bit, irq_out_n}, 8'h02);
    rdc(`FPC_ADDR_IRR, 8'h01);
    rdc(`FPC_ADDR_ISR_HI, 8'h01);
    settle();
    chk({6'h0, master_irq_bit, irq_out_n}, 8'h01);
    rdc(`FPC_ADDR_IRR, 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_power();
    t_modes();
    t_crc();
    t_soft();
    t_irq();
    results();
  end

endmodule
